// ==== verilog/hsfs_pkg.sv ====
// Behaviour
// - Supply monitor low: both drives off, 10mA.
// - Overcurrent fault: main drive off at 50mA.
// - Severe short: startup 130mA or main 600mA.
// - Device supply lockout: 130mA and 600mA pull-downs.
// - Startup limiter 100us timer expiry latches fault.
// - Startup fault timer idle while limiter disengaged.
// - Breaker filter counts up/down at equal rate.
// - Breaker trip: main off 50mA, latch fault.
// - After trip ramp to floor, 512 cool-off cycles.
// - Cool-off holds fault low, ignores reset request.
// - Main limiter engaged runs 100us fault timer.
// - Fast trip pulls main drive, no latch.
// - Output below 3.7V after power good latches fault.
// - Overcurrent faults after power good start cool-off, block restart; startup fault latches without cool-off.
// - Monitor low over 270us turns drives off.
// - Monitor below 0.6V clears fault, except cool-off.
// - Restart only after rise plus debounce.
// - Undervoltage turn-off releases fault, drops power good.
// - Rising monitor starts 25ms debounce before startup.
// - Monitor low through cool-off clears fault at end.
package hsfs_pkg;
   // Clock figures
   localparam int CLK_MHZ         = 100;               // System clock rate
   localparam int FAULT_US        = 100;               // Limiter fault window
   localparam int UV_FILT_US      = 270;               // Undervoltage filter
   localparam int DEBOUNCE_MS     = 25;                // Rising debounce
   localparam int FAULT_CYC       = FAULT_US * CLK_MHZ;
   localparam int UV_FILT_CYC     = UV_FILT_US * CLK_MHZ;
   localparam int DEBOUNCE_CYC    = DEBOUNCE_MS * 1000 * CLK_MHZ;
   // Breaker integrator levels in counts, and cool-off cycle count
   localparam logic [15:0] CB_TRIP   = 16'h3E80;        // Trip level
   localparam logic [15:0] CB_FLOOR  = 16'h0A28;        // Cool-off floor
   localparam logic [15:0] CB_STEP   = 16'h0001;        // Up/down step
   localparam logic [9:0]  COOL_CYCLES = 10'h200;       // 512 cool-off cycles
   // Pull-down strength selections
   typedef enum logic [2:0] {
      PD_NONE, PD_10MA, PD_50MA, PD_130MA, PD_600MA
   } hsfs_pd_type;
endpackage

// ==== verilog/hsfs_timer_if.sv ====
`timescale 1ns/10ps
// Run/clear and expiry handshake of one fault timer
interface hsfs_timer_if;
   logic run;      // Count while high, clear otherwise
   logic expired;  // Reached terminal count
   modport owner (output run, input expired);
   modport timer (input run, output expired);
endinterface

// ==== verilog/hsfs_timer.sv ====
`timescale 1ns/10ps
// Retriggerable run timer, clears whenever run drops
module hsfs_timer #(
   parameter int LIMIT = 10
) (
   input  wire logic  mclk,
   input  wire logic  rst,
   hsfs_timer_if.timer tif
);
   import hsfs_pkg::*;
   logic [31:0] cnt_ff;    // Elapsed cycles
   logic [31:0] nxt_cnt;   // Next count
   ////////////////////////////////////////////////////////////////////
   // Next count: hold at limit, clear when idle
   always_comb begin
      nxt_cnt = 32'h0;
      if (tif.run) begin
         nxt_cnt = (cnt_ff >= 32'(LIMIT)) ? cnt_ff : cnt_ff + 32'h1;
      end
   end
   // Register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_ff <= 32'h0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
   assign tif.expired = tif.run && (cnt_ff >= 32'(LIMIT));
endmodule

// ==== verilog/hsfs_sequencer.sv ====
`timescale 1ns/10ps
// Hot swap fault and turn-off sequencer
module hsfs_sequencer #(
   parameter int          DEBOUNCE_CYCLES = hsfs_pkg::DEBOUNCE_CYC,
   parameter logic [15:0] CB_STEP_SIZE    = hsfs_pkg::CB_STEP  // Integrator step, at most half the floor
) (
   input  wire logic               mclk,
   input  wire logic               rst,
   input  wire logic               supplyMonitorAboveRise,
   input  wire logic               supplyMonitorBelowFall,
   input  wire logic               supplyMonitorBelowReset,
   input  wire logic               supplyLockout,
   input  wire logic               startupLimiterActive,
   input  wire logic               startupSevereShort,
   input  wire logic               breakerSenseHigh,
   input  wire logic               mainLimiterActive,
   input  wire logic               fastTripLevel,
   input  wire logic               outputLow,
   input  wire logic               rampDone,
   output hsfs_pkg::hsfs_pd_type   startupPullDown,
   output hsfs_pkg::hsfs_pd_type   mainPullDown,
   output logic                    startupSwitchDriveEn,
   output logic                    mainSwitchDriveEn,
   output logic                    faultOutputN,
   output logic                    powerGoodOutput,
   output logic                    coolOffActive
);
   import hsfs_pkg::*;

   ////////////////////////////////////////////////////////////////////
   // State declarations
   typedef enum logic [2:0] {
      ST_OFF, ST_DEBOUNCE, ST_RAMP, ST_GOOD, ST_FLOOR, ST_COOL, ST_LATCHED
   } hsfs_state_type;

   hsfs_state_type state_ff;      // Sequencer state
   hsfs_state_type nxt_state;     // Next state
   logic [15:0]    cbTimer_ff;    // Breaker filter integrator
   logic [15:0]    nxt_cbTimer;   // Next integrator value
   logic           cbUp_ff;       // Cool-off ramp direction
   logic           nxt_cbUp;      // Next direction
   logic [9:0]     coolCnt_ff;    // Completed cool-off cycles
   logic [9:0]     nxt_coolCnt;   // Next cycle count
   logic           fault_ff;      // Latched fault
   logic           nxt_fault;     // Next latched fault
   logic           uvOff_ff;      // Undervoltage turn-off in force
   logic           nxt_uvOff;     // Next undervoltage flag
   hsfs_pd_type    pd1_ff;        // Startup pull-down selection
   hsfs_pd_type    nxt_pd1;       // Next startup selection
   hsfs_pd_type    pd2_ff;        // Main pull-down selection
   hsfs_pd_type    nxt_pd2;       // Next main selection
   logic           debDone;       // Debounce elapsed
   logic           startupFault;  // Startup limiter window elapsed
   logic           mainFault;     // Main limiter window elapsed
   logic           uvFiltered;    // Monitor low beyond filter time

   ////////////////////////////////////////////////////////////////////
   // Timers, all counted on mclk
   hsfs_timer_if debIf ();
   hsfs_timer_if suIf ();
   hsfs_timer_if mlIf ();
   hsfs_timer_if uvIf ();

   assign debIf.run = (state_ff == ST_DEBOUNCE) && supplyMonitorAboveRise;
   assign suIf.run  = (state_ff == ST_RAMP) && startupLimiterActive;
   assign mlIf.run  = (state_ff == ST_GOOD) && mainLimiterActive;
   assign uvIf.run  = supplyMonitorBelowFall && !supplyMonitorBelowReset;
   assign debDone      = debIf.expired;
   assign startupFault = suIf.expired;
   assign mainFault    = mlIf.expired;
   assign uvFiltered   = uvIf.expired;

   hsfs_timer #(.LIMIT(DEBOUNCE_CYCLES)) uDeb (.mclk(mclk), .rst(rst), .tif(debIf));
   hsfs_timer #(.LIMIT(FAULT_CYC))       uSu  (.mclk(mclk), .rst(rst), .tif(suIf));
   hsfs_timer #(.LIMIT(FAULT_CYC))       uMl  (.mclk(mclk), .rst(rst), .tif(mlIf));
   hsfs_timer #(.LIMIT(UV_FILT_CYC))     uUv  (.mclk(mclk), .rst(rst), .tif(uvIf));

   ////////////////////////////////////////////////////////////////////
   // Sequencer next-state logic
   always_comb begin
      nxt_state   = state_ff;
      nxt_cbTimer = cbTimer_ff;
      nxt_cbUp    = cbUp_ff;
      nxt_coolCnt = coolCnt_ff;
      nxt_fault   = fault_ff;
      nxt_uvOff   = uvOff_ff;
      nxt_pd1     = pd1_ff;
      nxt_pd2     = pd2_ff;
      case (state_ff)
         // Drives off, wait for monitor to rise
         ST_OFF: begin
            nxt_uvOff = 1'b0;
            if (supplyMonitorAboveRise && !fault_ff) begin
               nxt_state = ST_DEBOUNCE;
            end
         end
         // Debounce before startup drive charges
         ST_DEBOUNCE: begin
            if (!supplyMonitorAboveRise) begin
               nxt_state = ST_OFF;
            end else if (debDone) begin
               nxt_state = ST_RAMP;
               nxt_pd1   = PD_NONE;
               nxt_pd2   = PD_NONE;
            end
         end
         // Controlled ramp on the startup drive
         ST_RAMP: begin
            if (startupSevereShort) begin
               nxt_pd1 = PD_130MA;
            end else begin
               nxt_pd1 = PD_NONE;
            end
            if (startupFault) begin
               nxt_pd1   = PD_10MA;
               nxt_pd2   = PD_10MA;
               nxt_fault = 1'b1;
               nxt_state = ST_LATCHED;
            end else if (rampDone) begin
               nxt_state = ST_GOOD;
               nxt_pd1   = PD_10MA;
            end
         end
         // Power good: breaker, limiter, fast trip, output-low watch
         ST_GOOD: begin
            if (breakerSenseHigh) begin
               nxt_cbTimer = cbTimer_ff + CB_STEP_SIZE;
            end else if (cbTimer_ff > CB_STEP_SIZE) begin
               nxt_cbTimer = cbTimer_ff - CB_STEP_SIZE;
            end else begin
               nxt_cbTimer = 16'h0;                        // Stop at empty, never wrap
            end
            nxt_pd2 = fastTripLevel ? PD_600MA : PD_NONE;
            if (cbTimer_ff >= CB_TRIP || mainFault || outputLow) begin
               nxt_pd2   = outputLow ? PD_600MA : PD_50MA;
               nxt_fault = 1'b1;
               nxt_state = ST_FLOOR;
            end
         end
         // Ramp breaker timer down to its floor
         ST_FLOOR: begin
            if (cbTimer_ff > CB_FLOOR) begin
               nxt_cbTimer = cbTimer_ff - CB_STEP_SIZE;
            end else begin
               nxt_cbUp    = 1'b1;
               nxt_coolCnt = 10'h0;
               nxt_state   = ST_COOL;
            end
         end
         // Cool-off: 512 up/down cycles, reset request ignored
         ST_COOL: begin
            if (cbUp_ff) begin
               nxt_cbTimer = cbTimer_ff + CB_STEP_SIZE;
               if (cbTimer_ff >= CB_TRIP) begin
                  nxt_cbUp = 1'b0;
               end
            end else begin
               nxt_cbTimer = cbTimer_ff - CB_STEP_SIZE;
               if (cbTimer_ff <= CB_FLOOR) begin
                  nxt_cbUp    = 1'b1;
                  nxt_coolCnt = coolCnt_ff + 10'h1;
               end
            end
            if (nxt_coolCnt == COOL_CYCLES) begin
               nxt_cbTimer = 16'h0;
               nxt_state   = ST_LATCHED;
               if (supplyMonitorBelowReset) begin
                  nxt_fault = 1'b0;
               end
            end
         end
         // Latched off until reset request
         ST_LATCHED: begin
            if (!fault_ff) begin
               nxt_state = ST_OFF;
            end
         end
         default: begin
            nxt_state = ST_OFF;
         end
      endcase
      // Monitor turn-offs apply outside cool-off
      // A fault raised in this very cycle wins over the clear
      if (state_ff != ST_FLOOR && state_ff != ST_COOL && !(nxt_fault && !fault_ff)) begin
         if (supplyMonitorBelowReset) begin
            nxt_fault   = 1'b0;
            nxt_state   = ST_OFF;
            nxt_cbTimer = 16'h0;
            nxt_pd1     = PD_10MA;
            nxt_pd2     = PD_10MA;
         end else if (uvFiltered &&
                      (state_ff == ST_RAMP || state_ff == ST_GOOD)) begin
            nxt_uvOff   = 1'b1;
            nxt_state   = ST_OFF;
            nxt_cbTimer = 16'h0;
            nxt_pd1     = PD_10MA;
            nxt_pd2     = PD_10MA;
         end
      end
      // Lockout overrides everything: to ST_OFF, clears fault, integrator and cool count
      if (supplyLockout) begin
         nxt_state   = ST_OFF;
         nxt_fault   = 1'b0;
         nxt_cbTimer = 16'h0;
         nxt_coolCnt = 10'h0;
         nxt_pd1     = PD_130MA;
         nxt_pd2     = PD_600MA;
      end
   end

   // State registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_ff   <= ST_OFF;
         cbTimer_ff <= 16'h0;
         cbUp_ff    <= 1'b1;
         coolCnt_ff <= 10'h0;
         fault_ff   <= 1'b0;
         uvOff_ff   <= 1'b0;
         pd1_ff     <= PD_10MA;
         pd2_ff     <= PD_10MA;
      end else begin
         state_ff   <= nxt_state;
         cbTimer_ff <= nxt_cbTimer;
         cbUp_ff    <= nxt_cbUp;
         coolCnt_ff <= nxt_coolCnt;
         fault_ff   <= nxt_fault;
         uvOff_ff   <= nxt_uvOff;
         pd1_ff     <= nxt_pd1;
         pd2_ff     <= nxt_pd2;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Outputs
   assign startupPullDown      = pd1_ff;
   assign mainPullDown         = pd2_ff;
   assign startupSwitchDriveEn = (state_ff == ST_RAMP) && (pd1_ff == PD_NONE);
   assign mainSwitchDriveEn    = (state_ff == ST_GOOD) && (pd2_ff == PD_NONE);
   assign faultOutputN         = !fault_ff;
   assign powerGoodOutput      = (state_ff == ST_GOOD);
   assign coolOffActive        = (state_ff == ST_FLOOR) || (state_ff == ST_COOL);
endmodule

// ==== dv/hsfs_analog_model.sv ====
`timescale 1ns/10ps
// Comparator front end: turns coded analog levels into synchronised flags
module hsfs_analog_model (
   input  wire logic       mclk,
   input  wire logic [1:0] uvCode,                  // 0 <0.6V, 1 <1.182V, 2 band, 3 >1.232V
   input  wire logic [1:0] senseCode,               // 0 quiet, 1 >10mV, 2 >15mV, 3 >40mV
   output logic            supplyMonitorAboveRise,  // Rising threshold
   output logic            supplyMonitorBelowFall,  // Falling threshold
   output logic            supplyMonitorBelowReset, // Reset threshold
   output logic            breakerSenseHigh,        // Breaker level
   output logic            mainLimiterActive,       // Limiter level
   output logic            fastTripLevel            // Fast comparator
);
   ////////////////////////////////////////////////////////////////
   // Comparators settle through one register stage
   always_ff @(posedge mclk) begin
      supplyMonitorAboveRise  <= (uvCode == 2'h3);
      supplyMonitorBelowFall  <= (uvCode <= 2'h1);
      supplyMonitorBelowReset <= (uvCode == 2'h0);
      breakerSenseHigh        <= (senseCode >= 2'h1);
      mainLimiterActive       <= (senseCode >= 2'h2);
      fastTripLevel           <= (senseCode == 2'h3);
   end
endmodule

// ==== dv/hsfs_seq_chk.sv ====
`timescale 1ns/10ps
// Port-level checker of the fault sequencer
module hsfs_seq_chk
   import hsfs_pkg::*;
(
   input wire logic mclk, rst, supplyMonitorAboveRise, supplyMonitorBelowFall,
   input wire logic supplyMonitorBelowReset, supplyLockout, startupLimiterActive,
   input wire logic startupSevereShort, breakerSenseHigh, mainLimiterActive,
   input wire logic fastTripLevel, outputLow, rampDone,
   input wire hsfs_pkg::hsfs_pd_type startupPullDown, mainPullDown,
   input wire logic startupSwitchDriveEn, mainSwitchDriveEn, faultOutputN,
   input wire logic powerGoodOutput, coolOffActive
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   logic [15:0] lowCnt_ff;  // Cycles of monitor in the low band
   logic [15:0] nxt_lowCnt; // Next count, saturating
   ////////////////////////////////////////////////////////////////
   // Count consecutive cycles below fall but above reset
   always_comb begin
      nxt_lowCnt = 16'h0000;
      if (supplyMonitorBelowFall && !supplyMonitorBelowReset) begin
         nxt_lowCnt = (lowCnt_ff == 16'h7530) ? lowCnt_ff : lowCnt_ff + 16'h0001;
      end
   end
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) lowCnt_ff <= 16'h0000;
      else lowCnt_ff <= nxt_lowCnt;
   end
   ////////////////////////////////////////////////////////////////
   sequence s_fast;
      $rose(fastTripLevel) && powerGoodOutput;
   endsequence
   sequence s_coolEnd;
      $fell(coolOffActive) && supplyMonitorBelowReset;
   endsequence
   a_lockout_pull: assert property (supplyLockout |=>
      startupPullDown == PD_130MA && mainPullDown == PD_600MA) else $error("lockout pull-down");
   a_fast_trip: assert property (s_fast |-> ##[1:100] mainPullDown != PD_NONE)
      else $error("fast trip slow");
   a_cool_holds: assert property (coolOffActive && !supplyLockout && !$past(supplyLockout)
      |-> !faultOutputN) else $error("fault released in cool-off");
   a_start_rise: assert property ($rose(startupSwitchDriveEn)
      |-> $past(supplyMonitorAboveRise)) else $error("start without rise");
   a_fault_cause: assert property ($fell(faultOutputN) |-> $past(breakerSenseHigh
      || mainLimiterActive || outputLow || startupLimiterActive)) else $error("fault no cause");
   a_uv_off: assert property (lowCnt_ff > 16'h6978 && !supplyLockout |->
      mainPullDown == PD_10MA && startupPullDown == PD_10MA && !powerGoodOutput)
      else $error("uv turn-off missing");
   a_breaker_pd: assert property ($fell(faultOutputN) && $past(powerGoodOutput)
      && !$past(mainLimiterActive) && !$past(outputLow) |-> ##[0:1] mainPullDown == PD_50MA)
      else $error("breaker pull-down");
   a_reset_clear: assert property (supplyMonitorBelowReset && !coolOffActive
      && !$past(coolOffActive) |-> ##[0:2] (faultOutputN || coolOffActive))
      else $error("fault not cleared");
   a_cool_end: assert property (s_coolEnd |-> ##[0:1] faultOutputN)
      else $error("cool-off end kept fault");
endmodule
bind hsfs_sequencer hsfs_seq_chk i_hsfs_seq_chk (.*);

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
// Self-checking bench of the fault sequencer
module tb_top;
   import hsfs_pkg::*;
   localparam int DB = 20;          // Shortened debounce
   localparam logic [15:0] SB = 16'h0400;  // Coarse integrator step keeps cool-off short
   localparam int TRIP_N = (int'(CB_TRIP) + int'(SB) - 1) / int'(SB);  // Steps to trip
   localparam int COOL_MIN = 2 * int'(COOL_CYCLES) * ((int'(CB_TRIP) - int'(CB_FLOOR)) / int'(SB));
   logic mclk, rst, supplyLockout, rampDone;
   logic startupLimiterActive, startupSevereShort, outputLow; // Low except in t_su_fault and t_out_low
   logic [1:0] uvCode, senseCode;   // Analog levels to the model
   logic supplyMonitorAboveRise, supplyMonitorBelowFall, supplyMonitorBelowReset;
   logic breakerSenseHigh, mainLimiterActive, fastTripLevel;
   hsfs_pd_type startupPullDown, mainPullDown;
   logic startupSwitchDriveEn, mainSwitchDriveEn, faultOutputN, powerGoodOutput, coolOffActive;
   int err_count, cmp_count;
   hsfs_sequencer #(.DEBOUNCE_CYCLES(DB), .CB_STEP_SIZE(SB)) i_hsfs_sequencer (.*);
   hsfs_analog_model i_hsfs_analog_model (.*);
   ////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input bit ok, input string msg);
      cmp_count++;
      if (!ok) begin
         err_count++;
         $display("[ERR] %0t %s", $time, msg);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d, compares %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////
   // Rise, debounce, ramp, power good
   task automatic t_start();
      int n;
      n = 0;
      uvCode = 2'h3;
      while (startupSwitchDriveEn !== 1'b1 && n < 200) begin
         step(1);
         n++;
      end
      chk(n >= DB && n < 200, "startup timing");
      if (n >= 200) wrap_up();
      chk(startupPullDown === PD_NONE, "startup still pulled");
      rampDone = 1'b1;
      step(3);
      chk(powerGoodOutput === 1'b1, "no power good");
      chk(mainSwitchDriveEn === 1'b1, "main drive not enabled");
      rampDone = 1'b0;
   endtask
   // Startup severe short, then limiter window expiry and reset request
   task automatic t_su_fault();
      int n;
      n = 0;
      uvCode = 2'h3;
      while (startupSwitchDriveEn !== 1'b1 && n < 200) begin
         step(1);
         n++;
      end
      chk(n < 200, "no ramp for startup fault");
      if (n >= 200) wrap_up();
      startupSevereShort = 1'b1;
      step(2);
      chk(startupPullDown === PD_130MA && startupSwitchDriveEn === 1'b0, "severe short");
      startupSevereShort = 1'b0;
      startupLimiterActive = 1'b1;
      n = 0;
      while (faultOutputN !== 1'b0 && n < 12000) begin
         step(1);
         n++;
      end
      chk(n >= FAULT_CYC && n <= FAULT_CYC + 3, "startup fault time");
      if (n >= 12000) wrap_up();
      chk(startupPullDown === PD_10MA && coolOffActive === 1'b0, "startup fault pulls");
      startupLimiterActive = 1'b0;
      uvCode = 2'h0;
      step(3);
      chk(faultOutputN === 1'b1, "startup fault not cleared");
   endtask
   // Output collapse after power good starts a cool-off
   task automatic t_out_low();
      outputLow = 1'b1;
      step(2);
      chk(faultOutputN === 1'b0 && mainPullDown === PD_600MA, "output low trip");
      chk(coolOffActive === 1'b1, "no cool-off on output low");
      outputLow = 1'b0;
   endtask
   // Fast trip pulls main drive but latches nothing
   task automatic t_fast();
      senseCode = 2'h3;
      step(5);
      chk(mainPullDown !== PD_NONE, "fast trip no pull");
      chk(mainSwitchDriveEn === 1'b0, "main drive on in fast trip");
      chk(faultOutputN === 1'b1, "fast trip latched");
      senseCode = 2'h0;
      step(50);
   endtask
   // Filtered undervoltage turn-off
   task automatic t_uv();
      int n;
      n = 0;
      uvCode = 2'h1;
      while (mainPullDown !== PD_10MA && n < 30000) begin
         step(1);
         n++;
      end
      chk(n >= UV_FILT_CYC - 2 && n <= UV_FILT_CYC + 4, "uv filter time");
      if (n >= 30000) wrap_up();
      chk(startupPullDown === PD_10MA, "startup not 10mA");
      chk(faultOutputN === 1'b1 && powerGoodOutput === 1'b0, "uv outputs");
      uvCode = 2'h0;
      step(3);
      chk(faultOutputN === 1'b1 && startupSwitchDriveEn === 1'b0, "reset request");
   endtask
   // Breaker trip, cool-off with reset request held low
   task automatic t_breaker();
      int n;
      n = 0;
      senseCode = 2'h1;
      while (faultOutputN !== 1'b0 && n < 20000) begin
         step(1);
         n++;
      end
      chk(n >= TRIP_N + 1 && n <= TRIP_N + 3, "trip time");
      if (n >= 20000) wrap_up();
      chk(mainPullDown === PD_50MA, "trip pull-down");
      senseCode = 2'h0;
      step(3);
      chk(coolOffActive === 1'b1, "no cool-off");
      uvCode = 2'h0;
      step(100);
      chk(faultOutputN === 1'b0, "reset honoured in cool-off");
      n = 0;
      while (coolOffActive !== 1'b0 && n < 60000) begin
         step(1);
         n++;
      end
      chk(n >= COOL_MIN && n < 60000, "cool-off length");
      if (n >= 60000) wrap_up();
      step(3);
      chk(faultOutputN === 1'b1, "fault kept after cool-off");
   endtask
   // Device supply lockout
   task automatic t_lockout();
      supplyLockout = 1'b1;
      step(2);
      chk(startupPullDown === PD_130MA && mainPullDown === PD_600MA, "lockout");
      chk(faultOutputN === 1'b1 && coolOffActive === 1'b0, "lockout kept fault");
      supplyLockout = 1'b0;
      step(2);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      err_count = 0;
      cmp_count = 0;
      {supplyLockout, rampDone, startupLimiterActive, startupSevereShort, outputLow} = 5'h00;
      uvCode = 2'h2;
      senseCode = 2'h0;
      rst = 1'b1;
      repeat (20) @(posedge mclk);
      #1 rst = 1'b0;
      step(2);
      chk(startupPullDown === PD_10MA && mainPullDown === PD_10MA, "reset pulls");
      chk(faultOutputN === 1'b1 && powerGoodOutput === 1'b0, "reset outputs");
      t_start();
      t_fast();
      t_uv();
      t_su_fault();
      t_start();
      t_breaker();
      t_start();
      t_out_low();
      t_lockout();
      wrap_up();
   end
endmodule
